// *** logic/mmd_decoder.sv ***
// address decoder, vector priority and stack conventions
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - zero page 0000-004F selects I/O registers
// - high I/O FE00-FE1F, watchdog at FFFF
// - 0050 through 024F selects on-chip RAM
// - 176 RAM bytes lie in page zero
// - stack pointer is sixteen bits wide
// - stack pointer resets to 00FF
// - interrupt entry pushes five bytes
// - upper index byte is not stacked
// - subroutine call pushes two-byte return address
// - push decrements, pull increments stack pointer
// - user ROM spans BE00 through FDFF
// - FFD0-FFFF holds interrupt and reset vectors
// - vectors high-first; priority rises with address
// - fixed source order keyboard up to reset
// - security option hides ROM from outside
// - unimplemented access raises illegal-address reset
module mmd_decoder
(
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          valid_i,       // cpu access strobe
    input  wire logic [15:0]                   addr_i,
    input  wire logic                          ext_view_i,    // access comes from outside
    input  wire logic                          secure_i,      // mask security option
    input  wire logic                          illegal_en_i,  // illegal reset enable
    input  wire logic [mmd_pkg::VEC_COUNT-1:0] irq_req_i,     // bit0 = conversion done
    input  wire logic                          sp_load_i,
    input  wire logic [15:0]                   sp_val_i,
    input  wire logic                          push_irq_i,
    input  wire logic                          push_call_i,
    input  wire logic                          pull_i,
    output logic                               sel_io_o,
    output logic                               sel_ram_o,
    output logic                               sel_rom_o,
    output logic                               sel_vec_o,
    output logic                               sel_hio_o,
    output logic                               sel_wdg_o,
    output logic                               ram_page0_o,
    output logic                               rom_blocked_o,
    output logic                               illegal_rst_o,
    output logic                               vec_valid_o,
    output logic [15:0]                        vec_addr_o,
    output logic [15:0]                        sp_o,
    output logic                               stk_busy_o,
    output logic                               stk_push_o,
    output logic                               sp_out_of_ram_o
);
    import mmd_pkg::*;
    // decode is combinational from the raw bus, then one flop stage;
    // every select and flag therefore lags the access by one bus cycle
    // and stands for exactly that one cycle
    // all processes reset asynchronously to constant values
    mmd_region_t nxt_region;               // combinational region
    mmd_region_t region_ff;                // registered region select
    logic        nxt_illegal;
    logic        illegal_ff;
    logic        page0_ff;
    logic        blocked_ff;
    logic        vec_valid_ff;
    logic [15:0] vec_addr_ff;
    logic [4:0]  nxt_vec_idx;              // winning source index
    logic        nxt_vec_any;
    logic [VEC_COUNT-1:0] win;             // per-source win terms
    logic [VEC_COUNT-1:0] higher;          // any higher source pending
    logic        wdg_hit;
    logic [4:0]  hio_off;

    // low five address bits index the implemented-register mask
    // for the high page; unused offsets there count as unimplemented
    assign hio_off = addr_i[4:0];
    assign wdg_hit = (addr_i == WATCHDOG_ADDR);
    // address decode; ordered so only one region can win
    // the watchdog test comes before the vector range, so FFFF never
    // raises the vector select even though it is the reset low byte
    // a gap between regions falls through to the illegal branch
    always_comb
    begin
        nxt_region  = REG_NONE;
        nxt_illegal = 1'b0;
        if (!valid_i)
            nxt_region = REG_NONE;
        else if (addr_i <= ZP_IO_HI)
            nxt_region = REG_IO;
        else if (addr_i >= RAM_LO && addr_i <= RAM_HI)
            nxt_region = REG_RAM;
        else if (addr_i >= ROM_LO && addr_i <= ROM_HI)
            nxt_region = REG_ROM;
        else if (addr_i >= HIO_LO && addr_i <= HIO_HI)
        begin
            // only listed offsets are implemented
            if (HIO_MAP[hio_off])
                nxt_region = REG_HIO;
            else
                nxt_illegal = 1'b1;
        end
        else if (wdg_hit)
            nxt_region = REG_WDG;
        else if (addr_i >= VEC_LO)
            nxt_region = REG_VEC;
        else
            nxt_illegal = 1'b1;
    end
    // registered selects, one-hot by construction
    // a flop here keeps decode glitches off the peripheral selects
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            region_ff <= REG_NONE;
        else
            region_ff <= nxt_region;
    end
    // page-zero RAM flag: 0050..00FF is the 176 direct bytes
    // tells the core that direct addressing reaches this byte
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            page0_ff <= 1'b0;
        else
            page0_ff <= (nxt_region == REG_RAM) && (addr_i <= PAGE0_HI);
    end
    // security: outside reads of ROM or of vectors FFD0-FFFE are blocked
    // vectors are guarded too, since they point into protected code;
    // accesses by the core itself are never blocked
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            blocked_ff <= 1'b0;
        else
            blocked_ff <= secure_i && ext_view_i &&
                          (nxt_region == REG_ROM || nxt_region == REG_VEC);
    end
    // illegal address reset request, one cycle per bad access
    // the reset controller sees one pulse per bad access; with the
    // enable low the access still decodes as no region at all,
    // so nothing downstream ever sees a stray select
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            illegal_ff <= 1'b0;
        else
            illegal_ff <= nxt_illegal && illegal_en_i;
    end
    // priority: higher index (higher address) wins
    // higher[i] is high when any source above i is pending, so at
    // most one win term is high; the price is a 23-deep or-chain,
    // which is fine at the bus clock
    assign higher[VEC_COUNT-1] = 1'b0;
    genvar gi;
    generate
        for (gi = 0; gi < VEC_COUNT; gi++)
        begin : g_prio
            if (gi < VEC_COUNT - 1)
            begin : g_hi
                assign higher[gi] = higher[gi+1] | irq_req_i[gi+1];
            end
            assign win[gi] = irq_req_i[gi] & ~higher[gi];
        end
    endgenerate
    // encode the single winner
    // win is one-hot, so the last match is the only match
    always_comb
    begin
        nxt_vec_idx = 5'h00;
        nxt_vec_any = |irq_req_i;
        for (int i = 0; i < VEC_COUNT; i++)
        begin
            if (win[i])
                nxt_vec_idx = 5'(i);
        end
    end
    // vector high byte sits at FFD0 + 2*index
    // vectors are two bytes each, so the index moves two addresses;
    // the low byte at the next address is the core's own fetch
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            vec_valid_ff <= 1'b0;
            vec_addr_ff  <= VEC_LO;
        end
        else
        begin
            vec_valid_ff <= nxt_vec_any;
            vec_addr_ff  <= VEC_LO + {10'h000, nxt_vec_idx, 1'b0};
        end
    end
    // stack engine
    // frames are sequenced there a byte per cycle; the bytes-left
    // output is not needed at this level
    mmd_stack u_stack
    (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .load_i     (sp_load_i),
        .load_val_i (sp_val_i),
        .push_irq_i (push_irq_i),
        .push_call_i(push_call_i),
        .pull_i     (pull_i),
        .sp_o       (sp_o),
        .busy_o     (stk_busy_o),
        .push_o     (stk_push_o),
        .left_o     ()
    );
    // one region bit per select port, in the enum's bit order
    // bit 0 is the zero-page I/O select, bit 5 the watchdog
    assign sel_io_o        = region_ff[0];
    assign sel_ram_o       = region_ff[1];
    assign sel_rom_o       = region_ff[2];
    assign sel_vec_o       = region_ff[3];
    assign sel_hio_o       = region_ff[4];
    assign sel_wdg_o       = region_ff[5];
    assign ram_page0_o     = page0_ff;
    assign rom_blocked_o   = blocked_ff;
    assign illegal_rst_o   = illegal_ff;
    assign vec_valid_o     = vec_valid_ff;
    assign vec_addr_o      = vec_addr_ff;
    // flag only; keeping sp in RAM is software's job
    assign sp_out_of_ram_o = (sp_o < RAM_LO) || (sp_o > RAM_HI);
endmodule
`default_nettype wire

// *** logic/mmd_pkg.sv ***
// constants for the memory map decoder and stack helper
package mmd_pkg;
    localparam logic [15:0] ZP_IO_LO        = 16'h0000;
    localparam logic [15:0] ZP_IO_HI        = 16'h004F;
    localparam logic [15:0] RAM_LO          = 16'h0050;
    localparam logic [15:0] RAM_HI          = 16'h024F;
    localparam logic [15:0] PAGE0_HI        = 16'h00FF;
    localparam logic [15:0] ROM_LO          = 16'hBE00;
    localparam logic [15:0] ROM_HI          = 16'hFDFF;
    localparam logic [15:0] HIO_LO          = 16'hFE00;
    localparam logic [15:0] HIO_HI          = 16'hFE1F;
    localparam logic [15:0] VEC_LO          = 16'hFFD0;
    localparam logic [15:0] VEC_HI          = 16'hFFFF;
    localparam logic [15:0] WATCHDOG_ADDR   = 16'hFFFF;
    localparam logic [15:0] SP_RESET        = 16'h00FF;
    localparam logic [2:0]  IRQ_STACK_BYTES = 3'h5;
    localparam logic [2:0]  JSR_STACK_BYTES = 3'h2;
    localparam logic [4:0]  VEC_COUNT       = 5'h18;
    // implemented high-page register offsets within FE00..FE1F
    localparam logic [31:0] HIO_MAP         = 32'hBC03_F00B;
    // region select one-hot codes
    typedef enum logic [5:0] {
        REG_NONE = 6'h00,
        REG_IO   = 6'h01,
        REG_RAM  = 6'h02,
        REG_ROM  = 6'h04,
        REG_VEC  = 6'h08,
        REG_HIO  = 6'h10,
        REG_WDG  = 6'h20
    } mmd_region_t;
    // stack engine states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PUSH = 3'h2,
        ST_PULL = 3'h4
    } mmd_stk_state_t;
endpackage

// *** logic/mmd_stack.sv ***
// stack pointer with push sequencing and single-byte pull
`timescale 1ns/100ps
`default_nettype none
module mmd_stack
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        load_i,       // software writes sp
    input  wire logic [15:0] load_val_i,
    input  wire logic        push_irq_i,   // start interrupt frame
    input  wire logic        push_call_i,  // start call frame
    input  wire logic        pull_i,       // single byte pull
    output logic      [15:0] sp_o,
    output logic             busy_o,
    output logic             push_o,       // byte being pushed this cycle
    output logic      [2:0]  left_o
);
    import mmd_pkg::*;
    logic [15:0]    sp_ff;                 // stack pointer, full width
    logic [2:0]     cnt_ff;                // bytes left in frame
    mmd_stk_state_t state_ff;              // engine state
    // pointer: down on push, up on pull
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            sp_ff <= SP_RESET;
        else if (load_i)
            sp_ff <= load_val_i;
        else if (state_ff == ST_PUSH)
            sp_ff <= sp_ff - 16'h0001;
        else if (state_ff == ST_IDLE && pull_i)
            sp_ff <= sp_ff + 16'h0001;
    end
    // frame sequencer: irq frames five bytes, calls two
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 3'h0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (push_irq_i)
                    begin
                        state_ff <= ST_PUSH;
                        cnt_ff   <= IRQ_STACK_BYTES;
                    end
                    else if (push_call_i)
                    begin
                        state_ff <= ST_PUSH;
                        cnt_ff   <= JSR_STACK_BYTES;
                    end
                end
                ST_PUSH:
                begin
                    cnt_ff <= cnt_ff - 3'h1;
                    if (cnt_ff == 3'h1)
                        state_ff <= ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
    assign sp_o   = sp_ff;
    assign busy_o = (state_ff != ST_IDLE);
    assign push_o = (state_ff == ST_PUSH);
    assign left_o = cnt_ff;
endmodule
`default_nettype wire

// *** verif/mmd_decoder_monitor.sv ***
// concurrent checks on the memory map decoder ports
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder_mon
    import mmd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        valid_i,
    input wire logic [15:0] addr_i,
    input wire logic        ext_view_i,
    input wire logic        secure_i,
    input wire logic        illegal_en_i,
    input wire logic [23:0] irq_req_i,
    input wire logic        sp_load_i,
    input wire logic        push_irq_i,
    input wire logic        push_call_i,
    input wire logic        pull_i,
    input wire logic        sel_io_o,
    input wire logic        sel_ram_o,
    input wire logic        sel_rom_o,
    input wire logic        sel_vec_o,
    input wire logic        sel_hio_o,
    input wire logic        sel_wdg_o,
    input wire logic        ram_page0_o,
    input wire logic        rom_blocked_o,
    input wire logic        illegal_rst_o,
    input wire logic        vec_valid_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic [15:0] sp_o,
    input wire logic        stk_busy_o,
    input wire logic        stk_push_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // access inside the high register page
    wire logic in_hio = valid_i && addr_i >= HIO_LO && addr_i <= HIO_HI;
    // stack engine free to take a new request
    wire logic stk_ok = !stk_busy_o && !sp_load_i;
    property p_one; $onehot0({sel_io_o, sel_ram_o, sel_rom_o, sel_vec_o, sel_hio_o, sel_wdg_o}); endproperty
    property p_io; valid_i && addr_i <= ZP_IO_HI |=> sel_io_o; endproperty
    property p_ram; valid_i && addr_i >= RAM_LO && addr_i <= RAM_HI
        |=> sel_ram_o && (ram_page0_o == ($past(addr_i) <= PAGE0_HI)); endproperty
    property p_rom; valid_i && addr_i >= ROM_LO && addr_i <= ROM_HI
        |=> sel_rom_o && (rom_blocked_o == $past(secure_i && ext_view_i)); endproperty
    property p_vec; valid_i && addr_i >= VEC_LO && addr_i < VEC_HI |=> sel_vec_o; endproperty
    property p_hio; in_hio && HIO_MAP[addr_i[4:0]] |=> sel_hio_o; endproperty
    property p_wdg; valid_i && addr_i == WATCHDOG_ADDR |=> sel_wdg_o && !sel_vec_o; endproperty
    property p_ill; in_hio && !HIO_MAP[addr_i[4:0]] && illegal_en_i |=> illegal_rst_o && !sel_hio_o; endproperty
    property p_top; irq_req_i[23] |=> vec_valid_o && vec_addr_o == 16'hFFFE; endproperty
    property p_call; stk_ok && push_call_i && !push_irq_i |=> stk_push_o [*2] ##1 !stk_busy_o; endproperty
    property p_irq; stk_ok && push_irq_i |=> stk_push_o [*5] ##1 !stk_busy_o; endproperty
    property p_dec; stk_push_o && !sp_load_i |=> sp_o == $past(sp_o) - 16'h0001; endproperty
    property p_pull; stk_ok && pull_i && !push_irq_i && !push_call_i |=> sp_o == $past(sp_o) + 16'h0001; endproperty
    property p_rst; $fell(reset_i) |-> sp_o == SP_RESET; endproperty
    a_one: assert property (p_one) else $error("two region selects");
    a_io: assert property (p_io) else $error("io select missing");
    a_ram: assert property (p_ram) else $error("ram or page zero wrong");
    a_rom: assert property (p_rom) else $error("rom select or block wrong");
    a_vec: assert property (p_vec) else $error("vector select missing");
    a_hio: assert property (p_hio) else $error("high io select missing");
    a_wdg: assert property (p_wdg) else $error("watchdog select wrong");
    a_ill: assert property (p_ill) else $error("illegal reset missing");
    a_top: assert property (p_top) else $error("top vector wrong");
    a_call: assert property (p_call) else $error("call frame length wrong");
    a_irq: assert property (p_irq) else $error("interrupt frame length wrong");
    a_dec: assert property (p_dec) else $error("push did not decrement");
    a_pull: assert property (p_pull) else $error("pull did not increment");
    a_rst: assert property (p_rst) else $error("stack reset value wrong");
    c_irq: cover property (stk_ok && push_irq_i);
    c_ill: cover property (illegal_rst_o);
    c_blk: cover property (rom_blocked_o);
endmodule
bind mmd_decoder mmd_decoder_mon u_mon (.*);
`default_nettype wire

// *** verif/mmd_cpu_model.sv ***
// cpu core stand-in that puts accesses on the bus
`timescale 1ns/100ps
`default_nettype none
module mmd_cpu_model
(
    input  wire logic        clk_i,
    input  wire logic        req_i,       // issue one access
    input  wire logic [15:0] req_addr_i,
    output logic             valid_o,
    output logic      [15:0] addr_o
);
    logic [15:0] last_ff = 16'h0000; // last address driven
    // remember the address of each access
    always @(posedge clk_i)
    begin
        if (req_i)
        begin
            last_ff <= req_addr_i;
        end
    end
    // idle bus shows the inverse so a stale address never matches
    assign valid_o = req_i;
    assign addr_o  = req_i ? req_addr_i : ~last_ff;
endmodule
`default_nettype wire

// *** verif/memory_map_decoder_tb_top.sv ***
// self-checking bench for the memory map decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module memory_map_decoder_tb_top;
    import mmd_pkg::*;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        req = 1'b0, ext = 1'b0, sec = 1'b0, ill_en = 1'b0, ld = 1'b0, pi = 1'b0, pc = 1'b0, pl = 1'b0;
    logic [15:0] req_addr = 16'h0000, ld_val = 16'h0000, bus_addr, vec_addr, sp;
    logic [23:0] irq = 24'h000000;
    logic        bus_valid, s_io, s_ram, s_rom, s_vec, s_hio, s_wdg, pg0, blk, ill, vvld, busy, push, oor;
    int          fail_count = 0;
    int          samples_checked = 0;
    always #4 clk_i = ~clk_i;
    mmd_cpu_model u_cpu (.clk_i(clk_i), .req_i(req), .req_addr_i(req_addr), .valid_o(bus_valid), .addr_o(bus_addr));
    mmd_decoder u_dut (.clk_i(clk_i), .reset_i(reset_i), .valid_i(bus_valid), .addr_i(bus_addr),
        .ext_view_i(ext), .secure_i(sec), .illegal_en_i(ill_en), .irq_req_i(irq), .sp_load_i(ld),
        .sp_val_i(ld_val), .push_irq_i(pi), .push_call_i(pc), .pull_i(pl), .sel_io_o(s_io), .sel_ram_o(s_ram),
        .sel_rom_o(s_rom), .sel_vec_o(s_vec), .sel_hio_o(s_hio), .sel_wdg_o(s_wdg), .ram_page0_o(pg0),
        .rom_blocked_o(blk), .illegal_rst_o(ill), .vec_valid_o(vvld), .vec_addr_o(vec_addr), .sp_o(sp),
        .stk_busy_o(busy), .stk_push_o(push), .sp_out_of_ram_o(oor));
    // verdict and end of run
    task automatic summarize;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one access; m is {illegal enable, security, outside view}
    task automatic access(input logic [15:0] a, input logic [11:0] e, input logic [2:0] m);
        @(posedge clk_i);
        req <= 1'b1;
        req_addr <= a;
        {ill_en, sec, ext} <= m;
        @(posedge clk_i);
        req <= 1'b0;
        @(negedge clk_i);
        `CHK("region", e[8:0], {blk, ill, pg0, s_wdg, s_hio, s_vec, s_rom, s_ram, s_io})
    endtask
    // map edges, each range boundary and unlisted high offsets
    task automatic test_map;
        logic [27:0] tbl [22];
        tbl = '{28'h0000001, 28'h004F001, 28'h0050042, 28'h00FF042, 28'h0100002, 28'h024F002,
                28'h0250080, 28'hBDFF080, 28'hBE00004, 28'hFDFF004, 28'hFE00010, 28'hFE02080,
                28'hFE0B080, 28'hFE0C010, 28'hFE10010, 28'hFE11010,
                28'hFE1F010, 28'hFE20080, 28'hFFCF080, 28'hFFD0008, 28'hFFFE008, 28'hFFFF020};
        foreach (tbl[i]) access(tbl[i][27:12], tbl[i][11:0], 3'b100);
        $display("test_map done");
    endtask
    // outside view under security, and illegal reset disabled
    task automatic test_secure;
        access(16'hBE00, 12'h104, 3'b111);
        access(16'hBE00, 12'h004, 3'b110);
        access(16'hBE00, 12'h004, 3'b101);
        access(16'hFFD0, 12'h108, 3'b111);
        access(16'hFE02, 12'h000, 3'b000);
        $display("test_secure done");
    endtask
    // each source against the lowest one pending
    task automatic test_vec;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clk_i);
            irq <= 24'h000001 | (24'h000001 << i);
            @(posedge clk_i);
            @(negedge clk_i);
            `CHK("vector", {1'b1, VEC_LO + 16'(2 * i)}, {vvld, vec_addr})
        end
        @(posedge clk_i);
        irq <= 24'h000000;
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK("vec_valid", 1'b0, vvld)
        $display("test_vec done");
    endtask
    // one stack request, bounded wait for idle, then the pointer
    task automatic frame(input logic c, input logic i, input logic p, input logic [15:0] e);
        @(posedge clk_i);
        {pc, pi, pl} <= {c, i, p};
        @(posedge clk_i);
        {pc, pi, pl} <= 3'b000;
        @(negedge clk_i);
        `CHK("stk_push", {c | i, c | i}, {busy, push})
        for (int k = 0; k < 20 && busy !== 1'b0; k++) @(negedge clk_i);
        if (busy !== 1'b0)
        begin
            fail_count++;
            $display("mismatch stk_busy exp 0 got %b", busy);
            summarize();
        end
        `CHK("sp", e, sp)
    endtask
    // call, interrupt, pull, both pushes at once, then two loads
    task automatic test_stack;
        frame(1'b1, 1'b0, 1'b0, 16'h00FD);
        frame(1'b0, 1'b1, 1'b0, 16'h00F8);
        frame(1'b0, 1'b0, 1'b1, 16'h00F9);
        frame(1'b1, 1'b1, 1'b0, 16'h00F4);
        @(posedge clk_i);
        ld <= 1'b1;
        ld_val <= 16'h0300;
        @(posedge clk_i);
        ld <= 1'b0;
        @(negedge clk_i);
        `CHK("sp_load", 17'h10300, {oor, sp})
        @(posedge clk_i);
        ld <= 1'b1;
        ld_val <= RAM_HI;
        @(posedge clk_i);
        ld <= 1'b0;
        @(negedge clk_i);
        `CHK("sp_in_ram", {1'b0, RAM_HI}, {oor, sp})
        $display("test_stack done");
    endtask
    // reset, then every scenario in turn
    initial
    begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        `CHK("sp_reset", SP_RESET, sp)
        test_map();
        test_secure();
        test_vec();
        test_stack();
        summarize();
    end
endmodule
`default_nettype wire
